//--- include/p4mux_pkg.sv
package p4mux_pkg;

  // ----------------------------------------------------------------
  // Pin positions within port 4
  // ----------------------------------------------------------------
  localparam int PIN_I2C_CLK = 4;
  localparam int PIN_I2C_DAT = 7;
  localparam int PIN_CANA_RX = 5;
  localparam int PIN_CANA_TX = 6;
  localparam int PIN_CANB_RX = 4;
  localparam int PIN_CANB_TX = 7;
  localparam int PORT_WIDTH = 8;

  // ----------------------------------------------------------------
  // Reset values of the configuration bits
  // ----------------------------------------------------------------
  localparam logic RST_CANA_EN = 1'b1;
  localparam logic RST_CANB_EN = 1'b0;
  localparam logic RST_I2C_EN = 1'b0;
  localparam logic RST_MISC_EN = 1'b0;
  localparam logic RST_BUS_EN = 1'b0;
  localparam logic RST_PAR = 1'b0;

  // ----------------------------------------------------------------
  // Controller decode window: bits 15:9 select, bit 8 picks controller
  // ----------------------------------------------------------------
  localparam logic [15:0] CAN_WIN_BASE = 16'h1000; // Arbitrary placement
  localparam int CAN_SEL_BIT = 8;

  // ----------------------------------------------------------------
  // Resource figures
  // ----------------------------------------------------------------
  localparam logic [6:0] MSG_OBJ_PER_CAN = 7'h20;
  localparam int IRQ_LINES = 4;
  localparam logic [7:0] SEG_MASK_CAN = 8'h0f; // Four segment lines left

endpackage

//--- verilog/p4mux_top.sv
`timescale 1ns/10ps
// Functional notes
// RULE_01: I2C enable forces pins 4.4/4.7 open-drain.
// RULE_02: I2C clock on 4.4, data on 4.7.
// RULE_03: I2C disabled returns pins to port control.
// RULE_04: CAN A transmit 4.6, receive 4.5.
// RULE_05: CAN B transmit 4.7, receive 4.4.
// RULE_06: Software enables CANs before global bus enable.
// RULE_07: Reset: CAN A enabled, CAN B disabled.
// RULE_08: Same offsets, A8 picks controller, separate selects.
// RULE_09: CAN interrupts merged onto four shared lines.
// RULE_10: CAN in use leaves four segment lines.
// RULE_11: CAN transmit pins open-drain per port register.
// RULE_12: Parallel mode puts both CANs on 4.5/4.6.
// RULE_13: Software enables misc and bus before parallel.
// RULE_14: Both controllers together give 64 message objects.
// RULE_15: Parallel: shared receive, transmit low if either.
// RULE_16: I2C wins over CAN B without parallel.
module p4mux_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration writes
  input wire logic pcfg_wr,
  input wire logic pcfg_can_a_en,
  input wire logic pcfg_can_b_en,
  input wire logic pcfg_i2c_en,
  input wire logic pcfg_misc_en,
  input wire logic sys_wr,
  input wire logic sys_bus_en,
  input wire logic misc_wr,
  input wire logic misc_par,
  // Configuration status
  output logic can_a_en_r,
  output logic can_b_en_r,
  output logic i2c_en_r,
  output logic misc_en_r,
  output logic bus_en_r,
  output logic par_r,
  // Port 4 registers
  input wire logic [7:0] port4_data_reg,
  input wire logic [7:0] port4_direction_reg,
  input wire logic [7:0] port4_open_drain_reg,
  output logic [7:0] port4_pin_value_r,
  // Port 4 pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out_r,
  output logic [7:0] pin_oe_r,
  // CAN controllers
  input wire logic can_a_transmit,
  input wire logic can_b_transmit,
  output logic can_a_receive_r,
  output logic can_b_receive_r,
  // I2C controller
  input wire logic i2c_clk_drive_low,
  input wire logic i2c_dat_drive_low,
  output logic i2c_clk_in_r,
  output logic i2c_dat_in_r,
  // Peripheral bus decode
  input wire logic bus_sel,
  input wire logic [15:0] bus_addr,
  output logic can_a_cs_r,
  output logic can_b_cs_r,
  // Interrupts
  input wire logic [3:0] can_a_irq,
  input wire logic [3:0] can_b_irq,
  input wire logic [3:0] other_irq,
  output logic [3:0] bus_irq_r,
  // Segment address and resources
  input wire logic [7:0] seg_addr_req,
  output logic [7:0] seg_addr_en_r,
  output logic [6:0] msg_obj_total_r
);
  // ----------------------------------------------------------------
  // Configuration bits
  // ----------------------------------------------------------------
  // CAN enables lock once the bus is up, so a late change cannot glitch a live controller
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      {can_a_en_r, can_b_en_r} <= {p4mux_pkg::RST_CANA_EN, p4mux_pkg::RST_CANB_EN}; // [RULE_07]
    else if (pcfg_wr && !bus_en_r)
      {can_a_en_r, can_b_en_r} <= {pcfg_can_a_en, pcfg_can_b_en}; // [RULE_06]
  end
  // I2C and misc-register enables
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      {i2c_en_r, misc_en_r} <= {p4mux_pkg::RST_I2C_EN, p4mux_pkg::RST_MISC_EN};
    else if (pcfg_wr)
      {i2c_en_r, misc_en_r} <= {pcfg_i2c_en, pcfg_misc_en};
  end
  // Global peripheral bus enable
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      bus_en_r <= p4mux_pkg::RST_BUS_EN;
    else if (sys_wr)
      bus_en_r <= sys_bus_en;
  end
  // Parallel mode bit is only reachable with both enables set
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      par_r <= p4mux_pkg::RST_PAR;
    else if (misc_wr && misc_en_r && bus_en_r)
      par_r <= misc_par; // [RULE_13]
  end
  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pin_meta_r;
  logic [7:0] pin_sync_r;
  // Pins are asynchronous; only the second stage is used below
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      {pin_sync_r, pin_meta_r} <= 16'hffff;
    else
      {pin_sync_r, pin_meta_r} <= {pin_meta_r, pin_in};
  end
  // ----------------------------------------------------------------
  // Alternate function selection
  // ----------------------------------------------------------------
  logic canb_own; // CAN B owns pins 4.4/4.7
  logic canb_par; // CAN B folded onto 4.5/4.6
  logic tx_shared;
  logic [7:0] alt_act;
  logic [7:0] alt_val;
  logic [7:0] alt_od;
  logic [7:0] alt_in;
  // I2C takes precedence over CAN B on the outer pin pair
  assign canb_own = can_b_en_r && !par_r && !i2c_en_r; // [RULE_16] [RULE_12]
  assign canb_par = can_b_en_r && par_r;
  // Dominant low from either controller wins the shared line
  assign tx_shared = (can_a_en_r ? can_a_transmit : 1'b1) &
                     (canb_par ? can_b_transmit : 1'b1); // [RULE_15]
  // Per-pin alternate-function vectors
  always_comb
  begin
    alt_act = 8'h00;
    alt_val = 8'hff;
    alt_od = 8'h00;
    alt_in = 8'h00;
    if (can_a_en_r || canb_par)
    begin
      alt_act[p4mux_pkg::PIN_CANA_TX] = 1'b1; // [RULE_04]
      alt_val[p4mux_pkg::PIN_CANA_TX] = tx_shared;
      alt_in[p4mux_pkg::PIN_CANA_RX] = 1'b1; // [RULE_04]
    end
    if (canb_own)
    begin
      alt_act[p4mux_pkg::PIN_CANB_TX] = 1'b1; // [RULE_05]
      alt_val[p4mux_pkg::PIN_CANB_TX] = can_b_transmit;
      alt_in[p4mux_pkg::PIN_CANB_RX] = 1'b1; // [RULE_05]
    end
    if (i2c_en_r)
    begin
      alt_act[p4mux_pkg::PIN_I2C_CLK] = 1'b1; // [RULE_02]
      alt_val[p4mux_pkg::PIN_I2C_CLK] = !i2c_clk_drive_low;
      alt_od[p4mux_pkg::PIN_I2C_CLK] = 1'b1; // [RULE_01]
      alt_act[p4mux_pkg::PIN_I2C_DAT] = 1'b1; // [RULE_02]
      alt_val[p4mux_pkg::PIN_I2C_DAT] = !i2c_dat_drive_low;
      alt_od[p4mux_pkg::PIN_I2C_DAT] = 1'b1; // [RULE_01]
    end
  end
  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < p4mux_pkg::PORT_WIDTH; gi = gi + 1)
    begin : g_pin
      logic od;
      // Forced open-drain overrides the port register, which is then ignored
      assign od = alt_od[gi] | port4_open_drain_reg[gi];
      always_ff @(posedge clk)
      begin
        if (!rst_n || alt_in[gi])
          {pin_out_r[gi], pin_oe_r[gi]} <= 2'h0;
        else if (alt_act[gi])
        begin
          pin_out_r[gi] <= alt_val[gi];
          pin_oe_r[gi] <= od ? !alt_val[gi] : 1'b1; // [RULE_11] [RULE_01]
        end
        else
        begin
          pin_out_r[gi] <= port4_data_reg[gi]; // [RULE_03]
          pin_oe_r[gi] <= od ? (port4_direction_reg[gi] & !port4_data_reg[gi])
                             : port4_direction_reg[gi]; // [RULE_03]
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // Receive paths
  // ----------------------------------------------------------------
  // Disabled controllers see a recessive line
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      {can_a_receive_r, can_b_receive_r, i2c_clk_in_r, i2c_dat_in_r, port4_pin_value_r} <= 12'hfff;
    else
    begin
      can_a_receive_r <= can_a_en_r ? pin_sync_r[p4mux_pkg::PIN_CANA_RX] : 1'b1; // [RULE_04]
      can_b_receive_r <= canb_par ? pin_sync_r[p4mux_pkg::PIN_CANA_RX]
                       : (canb_own ? pin_sync_r[p4mux_pkg::PIN_CANB_RX] : 1'b1); // [RULE_15] [RULE_05]
      i2c_clk_in_r <= i2c_en_r ? pin_sync_r[p4mux_pkg::PIN_I2C_CLK] : 1'b1; // [RULE_02]
      i2c_dat_in_r <= i2c_en_r ? pin_sync_r[p4mux_pkg::PIN_I2C_DAT] : 1'b1;
      port4_pin_value_r <= pin_sync_r;
    end
  end
  // ----------------------------------------------------------------
  // Decode, interrupts, segment lines, message objects
  // ----------------------------------------------------------------
  logic win_hit;
  assign win_hit = bus_sel && (bus_addr[15:9] == p4mux_pkg::CAN_WIN_BASE[15:9]);
  // One select per controller; bit 8 alone tells them apart
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      {can_a_cs_r, can_b_cs_r} <= 2'h0;
    else
    begin
      can_a_cs_r <= win_hit && !bus_addr[p4mux_pkg::CAN_SEL_BIT] && can_a_en_r; // [RULE_08]
      can_b_cs_r <= win_hit && bus_addr[p4mux_pkg::CAN_SEL_BIT] && can_b_en_r; // [RULE_08]
    end
  end
  // Shared vectors: software must poll to find the source
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      bus_irq_r <= 4'h0;
    else
      bus_irq_r <= (can_a_en_r ? can_a_irq : 4'h0) | (can_b_en_r ? can_b_irq : 4'h0) | other_irq; // [RULE_09]
  end
  // Upper segment lines are lost while any CAN is in use
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      {seg_addr_en_r, msg_obj_total_r} <= 15'h0000;
    else
    begin
      seg_addr_en_r <= (can_a_en_r || can_b_en_r) ? (seg_addr_req & p4mux_pkg::SEG_MASK_CAN)
                                                  : seg_addr_req; // [RULE_10]
      msg_obj_total_r <= (can_a_en_r ? p4mux_pkg::MSG_OBJ_PER_CAN : 7'h00) +
                         (can_b_en_r ? p4mux_pkg::MSG_OBJ_PER_CAN : 7'h00); // [RULE_14]
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_i2c_od_force: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
    i2c_en_r && $stable(i2c_en_r) |=> !(pin_oe_r[p4mux_pkg::PIN_I2C_CLK] && pin_out_r[p4mux_pkg::PIN_I2C_CLK]))
    else $error("I2C clock pin driven high");
  a_i2c_clk_route: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_02]
    i2c_en_r && i2c_clk_drive_low |=> pin_oe_r[p4mux_pkg::PIN_I2C_CLK] || !i2c_en_r)
    else $error("I2C clock low not driven");
  a_port_return: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
    !i2c_en_r && !can_b_en_r && !port4_open_drain_reg[7] |=> pin_oe_r[7] == $past(port4_direction_reg[7]))
    else $error("Pin 4.7 not under port control");
  a_cana_tx_route: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_04]
    can_a_en_r && !par_r && !port4_open_drain_reg[6] |=> pin_oe_r[6] && pin_out_r[6] == $past(can_a_transmit))
    else $error("CAN A transmit not on 4.6");
  a_canb_rx_route: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_05]
    canb_own |=> can_b_receive_r == $past(pin_sync_r[p4mux_pkg::PIN_CANB_RX]))
    else $error("CAN B receive not from 4.4");
  a_enable_lock: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_06]
    bus_en_r && pcfg_wr |=> $stable(can_a_en_r) && $stable(can_b_en_r))
    else $error("CAN enable changed after bus enable");
  a_reset_enables: assert property (@(posedge clk) // [RULE_07]
    !rst_n |=> can_a_en_r && !can_b_en_r)
    else $error("Wrong CAN enables after reset");
  a_cs_split: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
    ##1 !(can_a_cs_r && can_b_cs_r))
    else $error("Both CAN selects active");
  a_seg_limit: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_10]
    (can_a_en_r || can_b_en_r) |=> seg_addr_en_r[7:4] == 4'h0)
    else $error("Upper segment lines enabled with CAN");
  a_par_gate: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_13]
    misc_wr && !(misc_en_r && bus_en_r) |=> $stable(par_r))
    else $error("Parallel bit written without enables");
  a_par_dominant: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_15]
    canb_par && !can_b_transmit && !port4_open_drain_reg[6] |=> pin_oe_r[6] && !pin_out_r[6])
    else $error("Shared transmit not dominant");
  a_i2c_priority: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_16]
    i2c_en_r && can_b_en_r && !par_r && i2c_dat_drive_low |=> pin_oe_r[7] && !pin_out_r[7])
    else $error("CAN B overrode I2C data pin");
  a_msg_total: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_14]
    can_a_en_r && can_b_en_r |=> msg_obj_total_r == 7'h40)
    else $error("Message object total wrong");

  c_parallel: cover property (@(posedge clk) disable iff (!rst_n) canb_par && can_a_en_r);
  c_i2c_on: cover property (@(posedge clk) disable iff (!rst_n) i2c_en_r && !i2c_dat_drive_low);
  c_both_can: cover property (@(posedge clk) disable iff (!rst_n) canb_own && can_a_en_r);

endmodule

//--- bench/p4mux_pins.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Far side of port 4: pull-ups, transceivers and I2C devices
// ----------------------------------------------------------------
module p4mux_pins (
  // Design pin drivers
  input wire logic [7:0] drv_out,
  input wire logic [7:0] drv_oe,
  // External devices pulling a line low
  input wire logic [7:0] ext_low,
  // Resolved line levels
  output logic [7:0] pin_level
);
  // A released line floats to its pull-up, so a stale value never shows
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      pin_level[i] = ~ext_low[i] & (drv_oe[i] ? drv_out[i] : 1'b1);
    end
  end
endmodule

//--- bench/tb.sv
`timescale 1ns/10ps
module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] cfg;
    logic [7:0] data, dir, od;
    logic [1:0] tx, il;
    logic [7:0] ext, oe, lvl;
    logic [3:0] rx;
  } p4mux_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pcfg_wr = 1'b0, pcfg_can_a_en = 1'b0, pcfg_can_b_en = 1'b0, pcfg_i2c_en = 1'b0, pcfg_misc_en = 1'b0;
  logic sys_wr = 1'b0, sys_bus_en = 1'b0, misc_wr = 1'b0, misc_par = 1'b0;
  logic can_a_en_r, can_b_en_r, i2c_en_r, misc_en_r, bus_en_r, par_r;
  logic [7:0] port4_data_reg = 8'h00, port4_direction_reg = 8'h00, port4_open_drain_reg = 8'h00, ext_low = 8'h00;
  logic [7:0] port4_pin_value_r, pin_in, pin_out_r, pin_oe_r, seg_addr_en_r;
  logic can_a_transmit = 1'b1, can_b_transmit = 1'b1, i2c_clk_drive_low = 1'b0, i2c_dat_drive_low = 1'b0;
  logic can_a_receive_r, can_b_receive_r, i2c_clk_in_r, i2c_dat_in_r, can_a_cs_r, can_b_cs_r;
  logic bus_sel = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic [3:0] can_a_irq = 4'h0, can_b_irq = 4'h0, other_irq = 4'h0, bus_irq_r;
  logic [7:0] seg_addr_req = 8'h00;
  logic [6:0] msg_obj_total_r;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  p4mux_row_t r;
  // Rows: {a,b,i2c,par}, data, dir, od, tx{a,b}, i2c low{clk,dat}, ext low, oe, level, rx{a,b,clk,dat}
  p4mux_row_t rows [8] = '{
    '{4'h0, 8'h5a, 8'h0f, 8'h00, 2'h3, 2'h0, 8'h00, 8'h0f, 8'hfa, 4'hf},
    '{4'h0, 8'h05, 8'hff, 8'hff, 2'h3, 2'h0, 8'h00, 8'hfa, 8'h05, 4'hf},
    '{4'h8, 8'h00, 8'h00, 8'h00, 2'h1, 2'h0, 8'h20, 8'h40, 8'h9f, 4'h7},
    '{4'hc, 8'h00, 8'h00, 8'h00, 2'h2, 2'h0, 8'h10, 8'hc0, 8'h6f, 4'hb},
    '{4'hc, 8'h00, 8'h00, 8'hc0, 2'h2, 2'h0, 8'h00, 8'h80, 8'h7f, 4'hf},
    '{4'he, 8'h00, 8'h90, 8'h00, 2'h0, 2'h2, 8'h00, 8'h50, 8'haf, 4'hd},
    '{4'hd, 8'h80, 8'h90, 8'h00, 2'h2, 2'h0, 8'h20, 8'hd0, 8'h8f, 4'h3},
    '{4'hf, 8'h00, 8'h00, 8'h00, 2'h3, 2'h1, 8'h00, 8'hc0, 8'h7f, 4'he}
  };

  // ----------------------------------------------------------------
  // Design and far side
  // ----------------------------------------------------------------
  p4mux_top DUT (
    .clk, .rst_n, .pcfg_wr, .pcfg_can_a_en, .pcfg_can_b_en, .pcfg_i2c_en, .pcfg_misc_en,
    .sys_wr, .sys_bus_en, .misc_wr, .misc_par, .can_a_en_r, .can_b_en_r, .i2c_en_r, .misc_en_r,
    .bus_en_r, .par_r, .port4_data_reg, .port4_direction_reg, .port4_open_drain_reg,
    .port4_pin_value_r, .pin_in, .pin_out_r, .pin_oe_r, .can_a_transmit, .can_b_transmit,
    .can_a_receive_r, .can_b_receive_r, .i2c_clk_drive_low, .i2c_dat_drive_low, .i2c_clk_in_r,
    .i2c_dat_in_r, .bus_sel, .bus_addr, .can_a_cs_r, .can_b_cs_r, .can_a_irq, .can_b_irq,
    .other_irq, .bus_irq_r, .seg_addr_req, .seg_addr_en_r, .msg_obj_total_r
  );
  p4mux_pins far_side (.drv_out(pin_out_r), .drv_oe(pin_oe_r), .ext_low(ext_low), .pin_level(pin_in));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  // Free-running system clock
  initial
  begin
    forever #5 clk = ~clk;
  end

  // A hang ends the run well past the expected hundred or so cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_count++;
      conclude();
    end
  end

  // Compare one value
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Unlock, load enables, relock, then set parallel mode in the allowed order
  task automatic setup(input logic [3:0] c);
    @(negedge clk);
    sys_wr = 1'b1;
    sys_bus_en = 1'b0;
    @(negedge clk);
    sys_wr = 1'b0;
    pcfg_wr = 1'b1;
    {pcfg_can_a_en, pcfg_can_b_en, pcfg_i2c_en} = c[3:1];
    pcfg_misc_en = 1'b1;
    @(negedge clk);
    pcfg_wr = 1'b0;
    sys_wr = 1'b1;
    sys_bus_en = 1'b1;
    @(negedge clk);
    sys_wr = 1'b0;
    misc_wr = 1'b1;
    misc_par = c[0];
    @(negedge clk);
    misc_wr = 1'b0;
  endtask

  task automatic conclude();
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    chk({can_a_en_r, can_b_en_r, i2c_en_r, misc_en_r, bus_en_r, par_r}, 6'h20);
    // Table of pin routings
    for (int i = 0; i < 8; i++)
    begin
      r = rows[i];
      setup(r.cfg);
      port4_data_reg = r.data;
      port4_direction_reg = r.dir;
      port4_open_drain_reg = r.od;
      {can_a_transmit, can_b_transmit} = r.tx;
      {i2c_clk_drive_low, i2c_dat_drive_low} = r.il;
      ext_low = r.ext;
      can_a_irq = 4'(i);
      can_b_irq = 4'(i + 5);
      seg_addr_req = 8'(8'h3c + i);
      bus_sel = 1'b1;
      bus_addr = p4mux_pkg::CAN_WIN_BASE | 16'h0100;
      repeat (6) @(negedge clk);
      chk({can_a_en_r, can_b_en_r, i2c_en_r, par_r}, r.cfg);
      chk(pin_oe_r, r.oe);
      chk(pin_in, r.lvl);
      chk(port4_pin_value_r, r.lvl);
      chk({can_a_receive_r, can_b_receive_r, i2c_clk_in_r, i2c_dat_in_r}, r.rx);
      chk({can_a_cs_r, can_b_cs_r}, {1'b0, r.cfg[2]});
      chk(bus_irq_r, (r.cfg[3] ? 4'(i) : 4'h0) | (r.cfg[2] ? 4'(i + 5) : 4'h0));
      chk(seg_addr_en_r, (r.cfg[3] | r.cfg[2]) ? seg_addr_req & p4mux_pkg::SEG_MASK_CAN : seg_addr_req);
      chk(msg_obj_total_r, (r.cfg[3] ? p4mux_pkg::MSG_OBJ_PER_CAN : 7'h00)
          + (r.cfg[2] ? p4mux_pkg::MSG_OBJ_PER_CAN : 7'h00));
    end
    // CAN enables are locked while the bus is on; misc writes refused once misc is off
    pcfg_wr = 1'b1;
    {pcfg_can_a_en, pcfg_can_b_en, pcfg_i2c_en, pcfg_misc_en} = 4'h0;
    @(negedge clk);
    pcfg_wr = 1'b0;
    misc_wr = 1'b1;
    misc_par = 1'b0;
    @(negedge clk);
    misc_wr = 1'b0;
    @(negedge clk);
    chk({can_a_en_r, can_b_en_r, i2c_en_r, misc_en_r}, 4'hc);
    chk(par_r, 1'b1);
    // Decode of controller A, and an address outside the window
    bus_addr = p4mux_pkg::CAN_WIN_BASE;
    other_irq = 4'h8;
    can_a_irq = 4'h1;
    can_b_irq = 4'h4;
    repeat (2) @(negedge clk);
    chk({can_a_cs_r, can_b_cs_r}, 2'h2);
    chk(bus_irq_r, 4'hd);
    bus_addr = p4mux_pkg::CAN_WIN_BASE + 16'h0200;
    repeat (2) @(negedge clk);
    chk({can_a_cs_r, can_b_cs_r}, 2'h0);
    // Second reset in mid-run
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk({can_a_en_r, can_b_en_r, i2c_en_r, misc_en_r, bus_en_r, par_r}, 6'h20);
    chk(pin_oe_r, 8'h00);
    conclude();
  end
endmodule
